// >>> fls_cmd_defs.vh
`ifndef FLS_CMD_DEFS_VH
`define FLS_CMD_DEFS_VH
// command codes
`define FLS_OFS_OPERATION 8'h01
`define FLS_OFS_ON_OFF_CFG 8'h02
`define FLS_OFS_SCALE_LOOP 8'h29
`define FLS_OFS_OUT_LOW_WARN 8'h43
`define FLS_OFS_OUT_LOW_FAULT 8'h44
`define FLS_OFS_OUT_LOW_ACT 8'h45
`define FLS_OFS_OC_FAULT 8'h46
`define FLS_OFS_OC_ACT 8'h47
`define FLS_OFS_OC_WARN 8'h4a
`define FLS_OFS_OT_FAULT 8'h4f
`define FLS_OFS_OT_ACT 8'h50
`define FLS_OFS_OT_WARN 8'h51
`define FLS_OFS_VIN_HIGH 8'h55
`define FLS_OFS_VIN_HIGH_ACT 8'h56
`define FLS_OFS_VIN_LOW_WARN 8'h58
`define FLS_OFS_GOOD_ON 8'h5e
`define FLS_OFS_GOOD_OFF 8'h5f
`define FLS_OFS_TURN_ON_DELAY_TIME 8'h60
`define FLS_OFS_TON_RAMP 8'h61
`define FLS_OFS_TON_TIMEOUT 8'h62
`define FLS_OFS_TON_TIMEOUT_ACT 8'h63
`define FLS_OFS_TURN_OFF_DELAY_TIME 8'h64
`define FLS_OFS_TURN_OFF_FALL_TIME 8'h65
// reset values
`define FLS_RST_OPERATION 16'h0000
`define FLS_RST_ON_OFF_CFG 16'h0016
`define FLS_RST_SCALE_LOOP 16'he808
`define FLS_RST_OUT_LOW_WARN 16'h0071
`define FLS_RST_OUT_LOW_FAULT 16'h0065
`define FLS_RST_OUT_LOW_ACT 16'h0000
`define FLS_RST_OC_FAULT 16'hf814
`define FLS_RST_OC_ACT 16'h0048
`define FLS_RST_OC_WARN 16'hf810
`define FLS_RST_OT_FAULT 16'h0091
`define FLS_RST_OT_ACT 16'h00c0
`define FLS_RST_OT_WARN 16'h007d
`define FLS_RST_VIN_HIGH 16'hf060
`define FLS_RST_VIN_HIGH_ACT 16'h0080
`define FLS_RST_VIN_LOW_WARN 16'hf801
`define FLS_RST_GOOD_ON 16'h0073
`define FLS_RST_GOOD_OFF 16'h006c
`define FLS_RST_TURN_ON_DELAY_TIME 16'h0000
`define FLS_RST_TON_RAMP 16'h0002
`define FLS_RST_TON_TIMEOUT 16'h0005
`define FLS_RST_TON_TIMEOUT_ACT 16'h0000
`define FLS_RST_TURN_OFF_DELAY_TIME 16'h0000
`define FLS_RST_TURN_OFF_FALL_TIME 16'h0001
// fields
`define FLS_EXP_MSB 15
`define FLS_EXP_LSB 11
`define FLS_ACT_MSB 7
`define FLS_ACT_LSB 6
`define FLS_OC_CNT_MSB 3
`define FLS_OP_ON 7
`define FLS_ONOFF_USE 4
`define FLS_ONOFF_CMD 3
`define FLS_ONOFF_PIN 2
`define FLS_ONOFF_POL 1
// timing
`define FLS_CLK_KHZ 25000
`define FLS_MS_TIME 1
`endif

// >>> fls_cmd_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "fls_cmd_defs.vh"
// Operation
// - output low warning below warn level
// - output under-voltage fault below fault level, in S_ON only
// - under-voltage action: ignore or shut down
// - over-current fault above limit, 3-10 A
// - over-current action, default pulse-limit 8 cycles
// - over-current warning above warn limit
// - over-temperature fault at limit, default 145
// - over-temperature action: ignore, shutdown, inhibit
// - over-temperature warning at warn limit
// - input over-voltage fault above threshold
// - input over-voltage action: ignore or shutdown
// - input low warning threshold, 0-16 V
// - power good asserts at scaled on-level
// - power good negates at scaled off-level
// - wait turn-on delay after start
// - ramp output over programmed rise time
// - power-up timeout fault before reaching fault level
// - power-up timeout action: ignore or shutdown
// - turn-off settings accepted but unused
// - loop scale only 1, 0.5, 0.25, 0.125
// - start from enable pin and commands
module fls_cmd_bank #(
	parameter MS_CYCLES = `FLS_CLK_KHZ * `FLS_MS_TIME
)(
	input wire core_clk,
	input wire nrst,
	input wire cmd_valid,
	input wire cmd_write,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	output reg resp_valid,
	output reg resp_ack,
	output reg [15:0] resp_rdata,
	input wire enable_pin,
	input wire sw_cycle,
	input wire [15:0] vout_meas,
	input wire [7:0] iout_meas,
	input wire [7:0] temp_meas,
	input wire [7:0] vin_meas,
	output reg power_on,
	output reg ramp_active,
	output reg power_good,
	output reg out_low_warn,
	output reg out_low_fault,
	output reg overcurrent_fault,
	output reg overcurrent_limit,
	output reg overcurrent_warn,
	output reg overheat_fault,
	output reg overheat_warn,
	output reg input_high_fault,
	output reg input_low_warn,
	output reg power_up_timeout_fault
);
	localparam NREG = 23;
	localparam [4:0] I_OP = 5'd0;
	localparam [4:0] I_ONOFF = 5'd1;
	localparam [4:0] I_SCALE = 5'd2;
	localparam [4:0] I_UVW = 5'd3;
	localparam [4:0] I_UVF = 5'd4;
	localparam [4:0] I_UVA = 5'd5;
	localparam [4:0] I_OCF = 5'd6;
	localparam [4:0] I_OCA = 5'd7;
	localparam [4:0] I_OCW = 5'd8;
	localparam [4:0] I_OTF = 5'd9;
	localparam [4:0] I_OTA = 5'd10;
	localparam [4:0] I_OTW = 5'd11;
	localparam [4:0] I_VOF = 5'd12;
	localparam [4:0] I_VOA = 5'd13;
	localparam [4:0] I_VIW = 5'd14;
	localparam [4:0] I_PGON = 5'd15;
	localparam [4:0] I_PGOFF = 5'd16;
	localparam [4:0] I_TOND = 5'd17;
	localparam [4:0] I_TONR = 5'd18;
	localparam [4:0] I_TMAX = 5'd19;
	localparam [4:0] I_TMAXA = 5'd20;
	localparam [4:0] I_TOFFD = 5'd21;
	localparam [4:0] I_TOFFF = 5'd22;
	localparam [4:0] I_NONE = 5'd31;
	localparam [1:0] ACT_IGNORE = 2'b00;
	localparam [1:0] ACT_DELAY = 2'b01;
	localparam [1:0] ACT_SHUT = 2'b10;
	localparam [1:0] ACT_INHIBIT = 2'b11;
	localparam [2:0] S_OFF = 3'd0;
	localparam [2:0] S_DELAY = 3'd1;
	localparam [2:0] S_RISE = 3'd2;
	localparam [2:0] S_ON = 3'd3;
	localparam [2:0] S_FAULT = 3'd4;
	localparam [2:0] S_INHIBIT = 3'd5;
	localparam integer DIV_LAST_FULL = MS_CYCLES - 1;
	localparam [14:0] DIV_LAST = DIV_LAST_FULL[14:0];
	localparam [6:0] CNT_MAX = 7'h7f;

	function [4:0] cmd_index;
		input [7:0] c;
		case (c)
			`FLS_OFS_OPERATION: cmd_index = I_OP;
			`FLS_OFS_ON_OFF_CFG: cmd_index = I_ONOFF;
			`FLS_OFS_SCALE_LOOP: cmd_index = I_SCALE;
			`FLS_OFS_OUT_LOW_WARN: cmd_index = I_UVW;
			`FLS_OFS_OUT_LOW_FAULT: cmd_index = I_UVF;
			`FLS_OFS_OUT_LOW_ACT: cmd_index = I_UVA;
			`FLS_OFS_OC_FAULT: cmd_index = I_OCF;
			`FLS_OFS_OC_ACT: cmd_index = I_OCA;
			`FLS_OFS_OC_WARN: cmd_index = I_OCW;
			`FLS_OFS_OT_FAULT: cmd_index = I_OTF;
			`FLS_OFS_OT_ACT: cmd_index = I_OTA;
			`FLS_OFS_OT_WARN: cmd_index = I_OTW;
			`FLS_OFS_VIN_HIGH: cmd_index = I_VOF;
			`FLS_OFS_VIN_HIGH_ACT: cmd_index = I_VOA;
			`FLS_OFS_VIN_LOW_WARN: cmd_index = I_VIW;
			`FLS_OFS_GOOD_ON: cmd_index = I_PGON;
			`FLS_OFS_GOOD_OFF: cmd_index = I_PGOFF;
			`FLS_OFS_TURN_ON_DELAY_TIME: cmd_index = I_TOND;
			`FLS_OFS_TON_RAMP: cmd_index = I_TONR;
			`FLS_OFS_TON_TIMEOUT: cmd_index = I_TMAX;
			`FLS_OFS_TON_TIMEOUT_ACT: cmd_index = I_TMAXA;
			`FLS_OFS_TURN_OFF_DELAY_TIME: cmd_index = I_TOFFD;
			`FLS_OFS_TURN_OFF_FALL_TIME: cmd_index = I_TOFFF;
			default: cmd_index = I_NONE;
		endcase
	endfunction

	function [15:0] reset_value;
		input [4:0] i;
		case (i)
			I_OP: reset_value = `FLS_RST_OPERATION;
			I_ONOFF: reset_value = `FLS_RST_ON_OFF_CFG;
			I_SCALE: reset_value = `FLS_RST_SCALE_LOOP;
			I_UVW: reset_value = `FLS_RST_OUT_LOW_WARN;
			I_UVF: reset_value = `FLS_RST_OUT_LOW_FAULT;
			I_UVA: reset_value = `FLS_RST_OUT_LOW_ACT;
			I_OCF: reset_value = `FLS_RST_OC_FAULT;
			I_OCA: reset_value = `FLS_RST_OC_ACT;
			I_OCW: reset_value = `FLS_RST_OC_WARN;
			I_OTF: reset_value = `FLS_RST_OT_FAULT;
			I_OTA: reset_value = `FLS_RST_OT_ACT;
			I_OTW: reset_value = `FLS_RST_OT_WARN;
			I_VOF: reset_value = `FLS_RST_VIN_HIGH;
			I_VOA: reset_value = `FLS_RST_VIN_HIGH_ACT;
			I_VIW: reset_value = `FLS_RST_VIN_LOW_WARN;
			I_PGON: reset_value = `FLS_RST_GOOD_ON;
			I_PGOFF: reset_value = `FLS_RST_GOOD_OFF;
			I_TOND: reset_value = `FLS_RST_TURN_ON_DELAY_TIME;
			I_TONR: reset_value = `FLS_RST_TON_RAMP;
			I_TMAX: reset_value = `FLS_RST_TON_TIMEOUT;
			I_TMAXA: reset_value = `FLS_RST_TON_TIMEOUT_ACT;
			I_TOFFD: reset_value = `FLS_RST_TURN_OFF_DELAY_TIME;
			I_TOFFF: reset_value = `FLS_RST_TURN_OFF_FALL_TIME;
			default: reset_value = 16'h0000;
		endcase
	endfunction

	function is_byte;
		input [4:0] i;
		is_byte = (i == I_OP) || (i == I_ONOFF) || (i == I_UVA) || (i == I_OCA) ||
			(i == I_OTA) || (i == I_VOA) || (i == I_TMAXA);
	endfunction

	// exponent must match exactly; mantissa taken unsigned so negatives fail
	function lin_ok;
		input [15:0] d;
		input [4:0] e;
		input [10:0] lo;
		input [10:0] hi;
		lin_ok = (d[`FLS_EXP_MSB:`FLS_EXP_LSB] == e) && (d[10:0] >= lo) && (d[10:0] <= hi);
	endfunction

	function write_ok;
		input [4:0] i;
		input [15:0] d;
		case (i)
			I_SCALE: write_ok = lin_ok(d, 5'h1d, 11'h001, 11'h008) && (d[3:0] == 4'h1 ||
				d[3:0] == 4'h2 || d[3:0] == 4'h4 || d[3:0] == 4'h8);
			I_OCF: write_ok = lin_ok(d, 5'h1f, 11'h006, 11'h014);
			I_OCW: write_ok = lin_ok(d, 5'h1f, 11'h000, 11'h07f);
			I_OTF: write_ok = lin_ok(d, 5'h00, 11'h000, 11'h096);
			I_OTW: write_ok = lin_ok(d, 5'h00, 11'h000, 11'h096);
			I_VOF: write_ok = lin_ok(d, 5'h1e, 11'h019, 11'h060);
			I_VIW: write_ok = lin_ok(d, 5'h1f, 11'h000, 11'h020);
			I_TOND, I_TONR, I_TMAX: write_ok = lin_ok(d, 5'h00, 11'h000, 11'h07f);
			I_TOFFD, I_TOFFF: write_ok = lin_ok(d, 5'h00, 11'h000, 11'h07f);
			default: write_ok = 1'b1;
		endcase
	endfunction

	function [1:0] act_kind;
		input [15:0] r;
		act_kind = r[`FLS_ACT_MSB:`FLS_ACT_LSB];
	endfunction

	reg [15:0] regs [0:NREG-1];
	integer k;
	wire [4:0] idx = cmd_index(cmd_code);

	// unmapped codes and out-of-range writes are refused without storing
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (k = 0; k < NREG; k = k + 1)
				regs[k] <= reset_value(k[4:0]);
			resp_valid <= 1'b0;
			resp_ack <= 1'b0;
			resp_rdata <= 16'h0000;
		end
		else
		begin
			resp_valid <= cmd_valid;
			if (cmd_valid)
			begin
				resp_rdata <= 16'h0000;
				resp_ack <= 1'b0;
				if (idx != I_NONE)
				begin
					if (cmd_write)
					begin
						if (write_ok(idx, cmd_wdata))
						begin
							resp_ack <= 1'b1;
							regs[idx] <= is_byte(idx) ? {8'h00, cmd_wdata[7:0]} : cmd_wdata;
						end
					end
					else
					begin
						resp_ack <= 1'b1;
						resp_rdata <= regs[idx];
					end
				end
			end
		end
	end

	wire [7:0] onoff = regs[I_ONOFF][7:0];
	wire pin_on = onoff[`FLS_ONOFF_POL] ? enable_pin : ~enable_pin;
	wire start_req = ~onoff[`FLS_ONOFF_USE] | ((~onoff[`FLS_ONOFF_CMD] | regs[I_OP][`FLS_OP_ON]) &
		(~onoff[`FLS_ONOFF_PIN] | pin_on));

	wire [3:0] scale_m = regs[I_SCALE][3:0];
	wire [19:0] pg_on_prod = {4'h0, regs[I_PGON]} * {16'h0000, scale_m};
	wire [19:0] pg_off_prod = {4'h0, regs[I_PGOFF]} * {16'h0000, scale_m};
	wire [15:0] pg_on_th = pg_on_prod[18:3];
	wire [15:0] pg_off_th = pg_off_prod[18:3];

	reg [2:0] state;
	reg [2:0] next_state;
	reg [14:0] div_cnt;
	reg [6:0] phase_cnt;
	reg [6:0] tmax_cnt;
	reg reached;
	reg [3:0] oc_cnt;

	wire ms_tick = (div_cnt == DIV_LAST);
	wire running = (state == S_RISE) || (state == S_ON);
	wire uv_now = vout_meas < regs[I_UVF];
	wire oc_over = iout_meas > regs[I_OCF][7:0];
	wire ot_now = temp_meas >= regs[I_OTF][7:0];
	wire vin_over = vin_meas > regs[I_VOF][7:0];
	wire [1:0] oc_kind = act_kind(regs[I_OCA]);
	wire [1:0] ot_kind = act_kind(regs[I_OTA]);
	wire uv_trip = (state == S_ON) && uv_now && (act_kind(regs[I_UVA]) == ACT_SHUT);
	// pulse limiting holds the current for the counted cycles, then gives up
	wire oc_trip = oc_over && (oc_kind == ACT_SHUT || oc_kind == ACT_INHIBIT ||
		(oc_kind == ACT_DELAY && oc_cnt >= regs[I_OCA][`FLS_OC_CNT_MSB:0]));
	wire ot_shut = ot_now && (ot_kind == ACT_SHUT);
	wire ot_inh = ot_now && (ot_kind == ACT_INHIBIT);
	wire vin_trip = vin_over && (act_kind(regs[I_VOA]) == ACT_SHUT);
	wire tmax_hit = running && !reached && (regs[I_TMAX][6:0] != 7'h00) &&
		(tmax_cnt >= regs[I_TMAX][6:0]);
	wire tmax_trip = tmax_hit && (act_kind(regs[I_TMAXA]) == ACT_SHUT);
	wire shut_trip = uv_trip | oc_trip | ot_shut | vin_trip | tmax_trip;
	wire next_run = (next_state == S_RISE) || (next_state == S_ON);

	always @*
	begin
		next_state = state;
		case (state)
			S_OFF:
				if (start_req)
					next_state = ot_inh ? S_INHIBIT : S_DELAY;
			S_DELAY:
				if (!start_req)
					next_state = S_OFF;
				else if (ot_inh)
					next_state = S_INHIBIT;
				else if (phase_cnt >= regs[I_TOND][6:0])
					next_state = S_RISE;
			S_RISE:
				if (!start_req)
					next_state = S_OFF;
				else if (ot_inh)
					next_state = S_INHIBIT;
				else if (shut_trip)
					next_state = S_FAULT;
				else if (phase_cnt >= regs[I_TONR][6:0])
					next_state = S_ON;
			S_ON:
				if (!start_req)
					next_state = S_OFF;
				else if (ot_inh)
					next_state = S_INHIBIT;
				else if (shut_trip)
					next_state = S_FAULT;
			S_FAULT:
				if (!start_req)
					next_state = S_OFF;
			S_INHIBIT:
				if (!start_req)
					next_state = S_OFF;
				else if (!ot_now)
					next_state = S_DELAY;
			default:
				next_state = S_OFF;
		endcase
	end

	// the millisecond divider restarts with each phase so delays are not short by a partial ms
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= S_OFF;
			div_cnt <= 15'h0000;
			phase_cnt <= 7'h00;
			tmax_cnt <= 7'h00;
			reached <= 1'b0;
			oc_cnt <= 4'h0;
		end
		else
		begin
			state <= next_state;
			if (next_state != state)
			begin
				div_cnt <= 15'h0000;
				phase_cnt <= 7'h00;
			end
			else
			begin
				div_cnt <= ms_tick ? 15'h0000 : div_cnt + 15'h0001;
				if (ms_tick && phase_cnt != CNT_MAX)
					phase_cnt <= phase_cnt + 7'h01;
			end
			if (!running)
			begin
				tmax_cnt <= 7'h00;
				reached <= 1'b0;
			end
			else
			begin
				if (!uv_now)
					reached <= 1'b1;
				if (ms_tick && !reached && tmax_cnt != CNT_MAX)
					tmax_cnt <= tmax_cnt + 7'h01;
			end
			if (!oc_over)
				oc_cnt <= 4'h0;
			else if (sw_cycle && oc_cnt != 4'hf)
				oc_cnt <= oc_cnt + 4'h1;
		end
	end

	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			power_on <= 1'b0;
			ramp_active <= 1'b0;
			power_good <= 1'b0;
			out_low_warn <= 1'b0;
			out_low_fault <= 1'b0;
			overcurrent_fault <= 1'b0;
			overcurrent_limit <= 1'b0;
			overcurrent_warn <= 1'b0;
			overheat_fault <= 1'b0;
			overheat_warn <= 1'b0;
			input_high_fault <= 1'b0;
			input_low_warn <= 1'b0;
			power_up_timeout_fault <= 1'b0;
		end
		else
		begin
			power_on <= next_run;
			ramp_active <= (next_state == S_RISE);
			if (!next_run)
				power_good <= 1'b0;
			else if (vout_meas >= pg_on_th)
				power_good <= 1'b1;
			else if (vout_meas <= pg_off_th)
				power_good <= 1'b0;
			out_low_warn <= vout_meas < regs[I_UVW];
			out_low_fault <= (state == S_ON) && uv_now;
			overcurrent_fault <= oc_over;
			overcurrent_limit <= oc_over && (oc_kind == ACT_DELAY);
			overcurrent_warn <= iout_meas > regs[I_OCW][7:0];
			overheat_fault <= ot_now;
			overheat_warn <= temp_meas >= regs[I_OTW][7:0];
			input_high_fault <= vin_over;
			input_low_warn <= vin_meas < {regs[I_VIW][6:0], 1'b0};
			// set wins: a hit in the restart cycle stays flagged
			if (tmax_hit)
				power_up_timeout_fault <= 1'b1;
			else if (next_state == S_DELAY && state != S_DELAY)
				power_up_timeout_fault <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> fls_cmd_bank_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fls_cmd_bank_sva (
	input wire core_clk,
	input wire nrst,
	input wire cmd_valid,
	input wire cmd_write,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	input wire resp_valid,
	input wire resp_ack,
	input wire [15:0] resp_rdata,
	input wire power_on,
	input wire ramp_active,
	input wire power_good,
	input wire overcurrent_fault,
	input wire power_up_timeout_fault
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire wr = cmd_valid && cmd_write;
	wire [4:0] ex = cmd_wdata[15:11];
	wire [10:0] mn = cmd_wdata[10:0];
	a_resp_next: assert property (cmd_valid |=> resp_valid)
		else $error("no answer one cycle after a command");
	a_resp_cause: assert property (resp_valid |-> $past(cmd_valid))
		else $error("answer without a command");
	a_unmapped_refused: assert property (cmd_valid && cmd_code == 8'h48 |=> !resp_ack && resp_rdata == 16'h0000)
		else $error("unmapped code not refused");
	a_oc_range: assert property (wr && cmd_code == 8'h46
		&& (ex != 5'h1f || mn < 11'h006 || mn > 11'h014) |=> !resp_ack)
		else $error("bad over-current limit accepted");
	a_ot_range: assert property (wr && (cmd_code == 8'h4f || cmd_code == 8'h51)
		&& (ex != 5'h00 || mn > 11'h096) |=> !resp_ack)
		else $error("bad temperature limit accepted");
	a_vin_range: assert property (wr && cmd_code == 8'h55
		&& (ex != 5'h1e || mn < 11'h019 || mn > 11'h060) |=> !resp_ack)
		else $error("bad input limit accepted");
	a_scale_values: assert property (wr && cmd_code == 8'h29
		&& !(cmd_wdata inside {16'he801, 16'he802, 16'he804, 16'he808}) |=> !resp_ack)
		else $error("bad loop scale accepted");
	a_toff_acked: assert property (wr && (cmd_code == 8'h64 || cmd_code == 8'h65)
		&& ex == 5'h00 && mn <= 11'h07f |=> resp_ack)
		else $error("turn-off setting refused");
	a_ramp_power: assert property (ramp_active |-> power_on)
		else $error("ramp without power stage");
	c_good: cover property ($rose(power_good));
	c_timeout: cover property ($rose(power_up_timeout_fault));
	c_oc: cover property ($rose(overcurrent_fault));
	c_shut: cover property ($fell(power_on));
endmodule
bind fls_cmd_bank fls_cmd_bank_sva i_sva (.core_clk, .nrst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
	.resp_valid, .resp_ack, .resp_rdata, .power_on, .ramp_active, .power_good, .overcurrent_fault,
	.power_up_timeout_fault);
`default_nettype wire

// >>> fls_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fls_host_model (
	input wire core_clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	input wire resp_valid,
	input wire resp_ack,
	input wire [15:0] resp_rdata
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// one command; idle code and data flip so a stale value is never mistaken for a live one
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic a,
		output logic [15:0] r);
		a = 1'bx;
		r = 16'hxxxx;
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code = c;
		cmd_wdata = d;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
		cmd_wdata = ~d;
		if (resp_valid === 1'b1)
		begin
			a = resp_ack;
			r = resp_rdata;
		end
	endtask
endmodule
`default_nettype wire

// >>> fls_cmd_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fls_cmd_defs.vh"
module fls_cmd_bank_tb;
	logic core_clk, nrst, enable_pin, sw_cycle;
	logic [15:0] vout_meas;
	logic [7:0] iout_meas, temp_meas, vin_meas;
	wire cmd_valid, cmd_write, resp_valid, resp_ack, power_on, ramp_active, power_good;
	wire out_low_warn, out_low_fault, overcurrent_fault, overcurrent_limit, overcurrent_warn;
	wire overheat_fault, overheat_warn, input_high_fault, input_low_warn, power_up_timeout_fault;
	wire [7:0] cmd_code;
	wire [15:0] cmd_wdata, resp_rdata;
	int err_count, checks;
	fls_cmd_bank #(.MS_CYCLES(10)) i_dut (.core_clk, .nrst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
		.resp_valid, .resp_ack, .resp_rdata, .enable_pin, .sw_cycle, .vout_meas, .iout_meas, .temp_meas,
		.vin_meas, .power_on, .ramp_active, .power_good, .out_low_warn, .out_low_fault, .overcurrent_fault,
		.overcurrent_limit, .overcurrent_warn, .overheat_fault, .overheat_warn, .input_high_fault,
		.input_low_warn, .power_up_timeout_fault);
	fls_host_model i_host (.core_clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .resp_valid, .resp_ack,
		.resp_rdata);
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic xf(input logic w, input logic [7:0] c, input logic [15:0] d, input logic ea,
		input logic [15:0] er);
		logic a;
		logic [15:0] r;
		i_host.xfer(w, c, d, a, r);
		check("ack", {15'h0000, a}, {15'h0000, ea});
		check("rdata", r, er);
	endtask
	// waits a bounded time for the output to settle on, returns cycles spent
	task automatic wait_on(input logic want_ramp, output int n);
		n = 0;
		while ((want_ramp ? power_on !== 1'b1 : ramp_active !== 1'b0) && n < 300)
		begin
			tick(1);
			n++;
		end
	endtask
	task automatic power_up;
		int n;
		enable_pin = 1'b0;
		tick(3);
		enable_pin = 1'b1;
		wait_on(1'b1, n);
		wait_on(1'b0, n);
		check("power on", power_on, 16'h0001);
	endtask
	task automatic t_regs;
		logic [23:0] tbl [20];
		tbl = '{{8'h43, `FLS_RST_OUT_LOW_WARN}, {8'h44, `FLS_RST_OUT_LOW_FAULT}, {8'h45, `FLS_RST_OUT_LOW_ACT},
			{8'h46, `FLS_RST_OC_FAULT}, {8'h47, `FLS_RST_OC_ACT}, {8'h4a, `FLS_RST_OC_WARN},
			{8'h4f, `FLS_RST_OT_FAULT}, {8'h50, `FLS_RST_OT_ACT}, {8'h51, `FLS_RST_OT_WARN},
			{8'h55, `FLS_RST_VIN_HIGH}, {8'h56, `FLS_RST_VIN_HIGH_ACT}, {8'h58, `FLS_RST_VIN_LOW_WARN},
			{8'h5e, `FLS_RST_GOOD_ON}, {8'h5f, `FLS_RST_GOOD_OFF}, {8'h60, `FLS_RST_TURN_ON_DELAY_TIME},
			{8'h61, `FLS_RST_TON_RAMP}, {8'h62, `FLS_RST_TON_TIMEOUT}, {8'h63, `FLS_RST_TON_TIMEOUT_ACT},
			{8'h64, `FLS_RST_TURN_OFF_DELAY_TIME}, {8'h65, `FLS_RST_TURN_OFF_FALL_TIME}};
		foreach (tbl[i])
			xf(1'b0, tbl[i][23:16], 16'h0000, 1'b1, tbl[i][15:0]);
		xf(1'b0, 8'h48, 16'h0000, 1'b0, 16'h0000);
		xf(1'b1, 8'h63, 16'h5540, 1'b1, 16'h0000);
		xf(1'b0, 8'h63, 16'h0000, 1'b1, 16'h0040);
		xf(1'b1, 8'h63, 16'h0000, 1'b1, 16'h0000);
	endtask
	task automatic t_flags;
		logic [47:0] tbl [4];
		tbl = '{{16'h0080, 8'h10, 8'h7c, 8'h60, 8'h00}, {16'h0070, 8'h11, 8'h7d, 8'h61, 8'h96},
			{16'h0064, 8'h15, 8'h91, 8'h01, 8'hbd}, {16'h0065, 8'h14, 8'h90, 8'h02, 8'h94}};
		foreach (tbl[i])
		begin
			{vout_meas, iout_meas, temp_meas, vin_meas} = tbl[i][47:8];
			tick(2);
			check("flags", {out_low_warn, out_low_fault, overcurrent_fault, overcurrent_warn, overheat_fault,
				overheat_warn, input_high_fault, input_low_warn}, tbl[i][7:0]);
		end
	endtask
	task automatic t_range;
		logic [24:0] tbl [15];
		tbl = '{{8'h46, 16'hf80b, 1'b1}, {8'h46, 16'hf805, 1'b0}, {8'h46, 16'hf815, 1'b0}, {8'h46, 16'h0014, 1'b0},
			{8'h4a, 16'hf87f, 1'b1}, {8'h4f, 16'h0097, 1'b0}, {8'h4f, 16'h0096, 1'b1}, {8'h55, 16'hf018, 1'b0},
			{8'h55, 16'hf019, 1'b1}, {8'h58, 16'hf821, 1'b0}, {8'h29, 16'he803, 1'b0}, {8'h29, 16'he804, 1'b1},
			{8'h64, 16'h007f, 1'b1}, {8'h65, 16'h0080, 1'b0}, {8'h60, 16'h0003, 1'b1}};
		foreach (tbl[i])
			xf(1'b1, tbl[i][24:17], tbl[i][16:1], tbl[i][0], 16'h0000);
		xf(1'b0, 8'h46, 16'h0000, 1'b1, 16'hf80b);
		xf(1'b0, 8'h64, 16'h0000, 1'b1, 16'h007f);
		xf(1'b1, 8'h55, 16'hf060, 1'b1, 16'h0000);
		xf(1'b1, 8'h29, 16'he808, 1'b1, 16'h0000);
	endtask
	task automatic t_seq;
		int n, m;
		{vout_meas, iout_meas, temp_meas, vin_meas} = {16'h0000, 8'h00, 8'h19, 8'h30};
		enable_pin = 1'b1;
		wait_on(1'b1, n);
		check("delay span", n >= 30 && n <= 33, 16'h0001);
		wait_on(1'b0, n);
		check("rise span", n >= 19 && n <= 22, 16'h0001);
		m = n;
		while (power_up_timeout_fault !== 1'b1 && m < 200)
		begin
			tick(1);
			m++;
		end
		check("timeout span", m >= 49 && m <= 53, 16'h0001);
		check("ignored timeout", power_on, 16'h0001);
	endtask
	task automatic t_good;
		logic [16:0] tbl [9];
		tbl = '{{16'h0072, 1'b0}, {16'h0073, 1'b1}, {16'h006d, 1'b1}, {16'h006c, 1'b0}, {16'h0073, 1'b1},
			{16'h0037, 1'b1}, {16'h0036, 1'b0}, {16'h0037, 1'b0}, {16'h003a, 1'b1}};
		foreach (tbl[i])
		begin
			if (i == 5)
				xf(1'b1, 8'h29, 16'he804, 1'b1, 16'h0000);
			vout_meas = tbl[i][16:1];
			tick(2);
			check("power good", power_good, tbl[i][0]);
		end
		xf(1'b1, 8'h29, 16'he808, 1'b1, 16'h0000);
		vout_meas = 16'h0060;
		tick(3);
		check("uv ignored", power_on, 16'h0001);
		check("uv fault", out_low_fault, 16'h0001);
		xf(1'b1, 8'h45, 16'h0080, 1'b1, 16'h0000);
		tick(2);
		check("uv shutdown", power_on, 16'h0000);
		xf(1'b1, 8'h45, 16'h0000, 1'b1, 16'h0000);
		vout_meas = 16'h0074;
	endtask
	task automatic t_trips;
		power_up();
		iout_meas = 8'h0c;
		repeat (7)
		begin
			sw_cycle = 1'b1;
			tick(1);
			sw_cycle = 1'b0;
			tick(1);
		end
		check("limiting", {overcurrent_limit, power_on}, 16'h0003);
		repeat (3)
		begin
			sw_cycle = 1'b1;
			tick(1);
			sw_cycle = 1'b0;
			tick(1);
		end
		check("oc shutdown", power_on, 16'h0000);
		iout_meas = 8'h00;
		power_up();
		temp_meas = 8'h96;
		tick(3);
		check("inhibit", power_on, 16'h0000);
		temp_meas = 8'h19;
		power_up();
		vin_meas = 8'h61;
		tick(3);
		check("vin shutdown", power_on, 16'h0000);
	endtask
	initial
	begin
		err_count = 0;
		checks = 0;
		{nrst, enable_pin, sw_cycle} = 3'b000;
		{vout_meas, iout_meas, temp_meas, vin_meas} = {16'h0080, 8'h00, 8'h19, 8'h30};
		tick(6);
		nrst = 1'b1;
		t_regs();
		t_flags();
		t_range();
		t_seq();
		t_good();
		t_trips();
		give_verdict();
	end
	initial
	begin
		repeat (8000) @(posedge core_clk);
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
